// >>> rtl/pter_defines.vh
// register offsets, reset values, field positions and timing constants of the timing/event bank
`ifndef PTER_DEFINES_VH
`define PTER_DEFINES_VH
`define PTER_A_INT_SUM     8'h00
`define PTER_A_INT_MASK    8'h01
`define PTER_A_PWR_EV      8'h02
`define PTER_A_PWR_EV_CLR  8'h03
`define PTER_A_DET_EV      8'h04
`define PTER_A_DET_EV_CLR  8'h05
`define PTER_A_FLT_EV      8'h06
`define PTER_A_FLT_EV_CLR  8'h07
`define PTER_A_STR_EV      8'h08
`define PTER_A_STR_EV_CLR  8'h09
`define PTER_A_SUP_EV      8'h0A
`define PTER_A_SUP_EV_CLR  8'h0B
`define PTER_A_PORT1_ST    8'h0C
`define PTER_A_PORT2_ST    8'h0D
`define PTER_A_PORT3_ST    8'h0E
`define PTER_A_PORT4_ST    8'h0F
`define PTER_A_PWR_ST      8'h10
`define PTER_A_PIN_ST      8'h11
`define PTER_A_TIMING_CFG  8'h16
`define PTER_A_PROG2       8'h27
`define PTER_A_PROG3       8'h28
`define PTER_RST_PROG2     8'h47
`define PTER_RST_PROG3     8'h77
`define PTER_RST_SUPPLY    8'h35
`define PTER_RST_ZERO      8'h00
`define PTER_HI_MSB        7
`define PTER_HI_LSB        4
`define PTER_LO_MSB        3
`define PTER_LO_LSB        0
`define PTER_SCALE_DOUBLE  2'h3
// times in microseconds, trip levels in microvolts
`define PTER_DISC_BASE_US  238000
`define PTER_DISC_STEP_US  16000
`define PTER_FLT_BASE_US   40960
`define PTER_FLT_STEP_US   2720
`define PTER_SU_BASE_UV    135000
`define PTER_SU_STEP_UV    19250
`define PTER_FLT_PCT       88
`define PTER_PCT_FULL      100
`define PTER_CLK_MHZ       20
`endif

// >>> rtl/pter_event_reg.v
// one sticky event register with read-only and clear-on-read views
`timescale 1ns/1ps
`default_nettype none
module pter_event_reg #(
  parameter [7:0] RESET_VAL = 8'h00
) (
  input  wire       ref_clk_i,
  input  wire       rst_i,
  input  wire [7:0] set_i,
  input  wire       clr_rd_i,
  output reg  [7:0] flags_o
);
  // set wins over a clear-on-read in the same cycle
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      flags_o <= RESET_VAL;
    end else if (clr_rd_i) begin
      flags_o <= set_i;
    end else begin
      flags_o <= flags_o | set_i;
    end
  end
endmodule // pter_event_reg
`default_nettype wire

// >>> rtl/pter_time_calc.v
// effective time from nominal code and two-bit coarse scale
`timescale 1ns/1ps
`default_nettype none
`include "pter_defines.vh"
module pter_time_calc #(
  parameter [31:0] BASE_US = `PTER_FLT_BASE_US,
  parameter [31:0] STEP_US = `PTER_FLT_STEP_US
) (
  input  wire        ref_clk_i,
  input  wire        rst_i,
  input  wire [3:0]  code_i,
  input  wire [1:0]  scale_i,
  output reg  [31:0] time_us_o,
  output reg  [31:0] cycles_o
);
  reg [31:0] nominal_nxt;
  reg [31:0] eff_nxt;
  // scale 00 keeps nominal, 01 quarters it, 10 halves it, 11 doubles it
  always @* begin
    nominal_nxt = BASE_US + STEP_US * {28'h0000000, code_i};
    case (scale_i)
      2'h0:    eff_nxt = nominal_nxt;
      2'h1:    eff_nxt = nominal_nxt >> 2;
      2'h2:    eff_nxt = nominal_nxt >> 1;
      `PTER_SCALE_DOUBLE: eff_nxt = nominal_nxt << 1;
      default: eff_nxt = nominal_nxt;
    endcase
  end
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      time_us_o <= 32'h00000000;
      cycles_o  <= 32'h00000000;
    end else begin
      time_us_o <= eff_nxt;
      cycles_o  <= eff_nxt * `PTER_CLK_MHZ;
    end
  end
endmodule // pter_time_calc
`default_nettype wire

// >>> rtl/pter_regs.v
// timing program registers and event/status register map of the quad port controller
`timescale 1ns/1ps
`default_nettype none
`include "pter_defines.vh"
module pter_regs (
  input  wire        ref_clk_i,
  input  wire        rst_i,
  input  wire [7:0]  addr_i,
  input  wire        wr_i,
  input  wire        rd_i,
  input  wire [7:0]  wdata_i,
  input  wire [1:0]  disconnect_time_scale_i,
  input  wire [1:0]  fault_timeout_scale_i,
  input  wire [1:0]  startup_timeout_scale_i,
  input  wire [7:0]  power_event_set_i,
  input  wire [7:0]  detect_event_set_i,
  input  wire [7:0]  fault_event_set_i,
  input  wire [7:0]  startup_event_set_i,
  input  wire [7:0]  supply_event_set_i,
  input  wire [7:0]  supply_event_init_i,
  input  wire [7:0]  port1_status_i,
  input  wire [7:0]  port2_status_i,
  input  wire [7:0]  port3_status_i,
  input  wire [7:0]  port4_status_i,
  input  wire [7:0]  power_state_i,
  input  wire        auto_pin_i,
  input  wire        midspan_pin_i,
  input  wire [3:0]  slave_address_pins_i,
  output reg  [7:0]  rdata_o,
  output reg  [3:0]  current_limit_code_o,
  output reg  [3:0]  disconnect_time_code_o,
  output reg  [3:0]  fault_timeout_code_o,
  output reg  [3:0]  startup_timeout_code_o,
  output wire [31:0] disconnect_time_us_o,
  output wire [31:0] disconnect_time_cycles_o,
  output wire [31:0] fault_timeout_us_o,
  output wire [31:0] fault_timeout_cycles_o,
  output wire [31:0] startup_timeout_us_o,
  output wire [31:0] startup_timeout_cycles_o,
  output reg  [31:0] startup_trip_voltage_uv_o,
  output reg  [31:0] fault_trip_voltage_uv_o,
  output reg  [7:0]  interrupt_mask_o,
  output reg  [7:0]  interrupt_summary_o
);
  reg  [7:0]  limit_and_disconnect_time_r;
  reg  [7:0]  fault_and_start_time_r;
  reg  [7:0]  pin_state_r;
  reg         strap_pending_r;
  reg  [7:0]  rdata_nxt;
  reg  [31:0] su_trip_nxt;
  wire [7:0]  power_ev;
  wire [7:0]  detect_ev;
  wire [7:0]  fault_ev;
  wire [7:0]  start_ev;
  wire [7:0]  supply_ev;
  wire [7:0]  supply_set;

  // summary flags, two each for power, detect and fault events, one each for startup and supply
  wire        sum_supply;
  wire        sum_start;
  wire        sum_limit;
  wire        sum_class;
  wire        sum_detect;
  wire        sum_disc;
  wire        sum_good;
  wire        sum_enable;

  function hit_rd;
    input [7:0] a;
    input [7:0] target;
    begin
      hit_rd = rd_i && (a == target);
    end
  endfunction

  function hit_wr;
    input [7:0] a;
    input [7:0] target;
    begin
      hit_wr = wr_i && (a == target);
    end
  endfunction

  // program registers, written from the serial slave port
  // writes in the strap cycle are dropped so the reset image holds for one edge
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      limit_and_disconnect_time_r <= `PTER_RST_PROG2;
    end else if (!strap_pending_r && hit_wr(addr_i, `PTER_A_PROG2)) begin
      limit_and_disconnect_time_r <= wdata_i;
    end
  end

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      fault_and_start_time_r <= `PTER_RST_PROG3;
    end else if (!strap_pending_r && hit_wr(addr_i, `PTER_A_PROG3)) begin
      fault_and_start_time_r <= wdata_i;
    end
  end

  // mask bits 7,6,5 and 2 follow the auto pin out of reset
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      interrupt_mask_o <= `PTER_RST_ZERO;
    end else if (strap_pending_r) begin
      interrupt_mask_o <= {{3{auto_pin_i}}, 2'h0, auto_pin_i, 2'h0};
    end else if (hit_wr(addr_i, `PTER_A_INT_MASK)) begin
      interrupt_mask_o <= wdata_i;
    end
  end

  // straps are caught by a clocked process on the first edge after reset release
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      strap_pending_r <= 1'h1;
    end else begin
      strap_pending_r <= 1'h0;
    end
  end

  // pin state is resampled every cycle so strap changes show up live
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      pin_state_r <= `PTER_RST_ZERO;
    end else begin
      pin_state_r <= {2'h0, slave_address_pins_i, midspan_pin_i, auto_pin_i};
    end
  end

  // summary bits in summary register order
  assign sum_supply = |supply_ev;
  assign sum_start  = |start_ev[3:0];
  assign sum_limit  = |fault_ev[3:0];
  assign sum_class  = |detect_ev[7:4];
  assign sum_detect = |detect_ev[3:0];
  assign sum_disc   = |fault_ev[7:4];
  assign sum_good   = |power_ev[7:4];
  assign sum_enable = |power_ev[3:0];

  // supply power-up order is ORed onto the reset value on the edge straps are sampled
  assign supply_set = strap_pending_r ? supply_event_init_i : supply_event_set_i;

  pter_event_reg #(.RESET_VAL(`PTER_RST_ZERO)) u_power_ev (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .set_i     (power_event_set_i),
    .clr_rd_i  (hit_rd(addr_i, `PTER_A_PWR_EV_CLR)),
    .flags_o   (power_ev)
  );
  pter_event_reg #(.RESET_VAL(`PTER_RST_ZERO)) u_detect_ev (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .set_i     (detect_event_set_i),
    .clr_rd_i  (hit_rd(addr_i, `PTER_A_DET_EV_CLR)),
    .flags_o   (detect_ev)
  );
  pter_event_reg #(.RESET_VAL(`PTER_RST_ZERO)) u_fault_ev (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .set_i     (fault_event_set_i),
    .clr_rd_i  (hit_rd(addr_i, `PTER_A_FLT_EV_CLR)),
    .flags_o   (fault_ev)
  );
  pter_event_reg #(.RESET_VAL(`PTER_RST_ZERO)) u_start_ev (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .set_i     (startup_event_set_i),
    .clr_rd_i  (hit_rd(addr_i, `PTER_A_STR_EV_CLR)),
    .flags_o   (start_ev)
  );
  pter_event_reg #(.RESET_VAL(`PTER_RST_SUPPLY)) u_supply_ev (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .set_i     (supply_set),
    .clr_rd_i  (hit_rd(addr_i, `PTER_A_SUP_EV_CLR)),
    .flags_o   (supply_ev)
  );

  // effective times from nominal codes and coarse scales
  pter_time_calc #(
    .BASE_US (`PTER_DISC_BASE_US),
    .STEP_US (`PTER_DISC_STEP_US)
  ) u_disc_time (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .code_i    (limit_and_disconnect_time_r[`PTER_LO_MSB:`PTER_LO_LSB]),
    .scale_i   (disconnect_time_scale_i),
    .time_us_o (disconnect_time_us_o),
    .cycles_o  (disconnect_time_cycles_o)
  );
  pter_time_calc #(
    .BASE_US (`PTER_FLT_BASE_US),
    .STEP_US (`PTER_FLT_STEP_US)
  ) u_fault_time (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .code_i    (fault_and_start_time_r[`PTER_HI_MSB:`PTER_HI_LSB]),
    .scale_i   (fault_timeout_scale_i),
    .time_us_o (fault_timeout_us_o),
    .cycles_o  (fault_timeout_cycles_o)
  );
  pter_time_calc #(
    .BASE_US (`PTER_FLT_BASE_US),
    .STEP_US (`PTER_FLT_STEP_US)
  ) u_start_time (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .code_i    (fault_and_start_time_r[`PTER_LO_MSB:`PTER_LO_LSB]),
    .scale_i   (startup_timeout_scale_i),
    .time_us_o (startup_timeout_us_o),
    .cycles_o  (startup_timeout_cycles_o)
  );

  // code fields and trip voltages registered for the port logic
  always @* begin
    su_trip_nxt = `PTER_SU_BASE_UV + `PTER_SU_STEP_UV *
                  {28'h0000000, limit_and_disconnect_time_r[`PTER_HI_MSB:`PTER_HI_LSB]};
  end

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      current_limit_code_o      <= 4'h0;
      disconnect_time_code_o    <= 4'h0;
      fault_timeout_code_o      <= 4'h0;
      startup_timeout_code_o    <= 4'h0;
    end else begin
      current_limit_code_o   <= limit_and_disconnect_time_r[`PTER_HI_MSB:`PTER_HI_LSB];
      disconnect_time_code_o <= limit_and_disconnect_time_r[`PTER_LO_MSB:`PTER_LO_LSB];
      fault_timeout_code_o   <= fault_and_start_time_r[`PTER_HI_MSB:`PTER_HI_LSB];
      startup_timeout_code_o <= fault_and_start_time_r[`PTER_LO_MSB:`PTER_LO_LSB];
    end
  end

  // both trip levels come from one term so they never disagree for a cycle
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      startup_trip_voltage_uv_o <= 32'h00000000;
      fault_trip_voltage_uv_o   <= 32'h00000000;
    end else begin
      startup_trip_voltage_uv_o <= su_trip_nxt;
      // integer divide truncates; the loss is below one microvolt
      fault_trip_voltage_uv_o <= (su_trip_nxt * `PTER_FLT_PCT) / `PTER_PCT_FULL;
    end
  end

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      interrupt_summary_o <= `PTER_RST_ZERO;
    end else begin
      interrupt_summary_o <= {sum_supply, sum_start, sum_limit, sum_class,
                              sum_detect, sum_disc, sum_good, sum_enable};
    end
  end

  // read mux; unmapped offsets read zero
  always @* begin
    case (addr_i)
      `PTER_A_INT_SUM:    rdata_nxt = interrupt_summary_o;
      `PTER_A_INT_MASK:   rdata_nxt = interrupt_mask_o;
      `PTER_A_PWR_EV,
      `PTER_A_PWR_EV_CLR: rdata_nxt = power_ev;
      `PTER_A_DET_EV,
      `PTER_A_DET_EV_CLR: rdata_nxt = detect_ev;
      `PTER_A_FLT_EV,
      `PTER_A_FLT_EV_CLR: rdata_nxt = fault_ev;
      `PTER_A_STR_EV,
      `PTER_A_STR_EV_CLR: rdata_nxt = start_ev;
      `PTER_A_SUP_EV,
      `PTER_A_SUP_EV_CLR: rdata_nxt = supply_ev;
      `PTER_A_PORT1_ST:   rdata_nxt = port1_status_i;
      `PTER_A_PORT2_ST:   rdata_nxt = port2_status_i;
      `PTER_A_PORT3_ST:   rdata_nxt = port3_status_i;
      `PTER_A_PORT4_ST:   rdata_nxt = port4_status_i;
      `PTER_A_PWR_ST:     rdata_nxt = power_state_i;
      `PTER_A_PIN_ST:     rdata_nxt = pin_state_r;
      `PTER_A_PROG2:      rdata_nxt = limit_and_disconnect_time_r;
      `PTER_A_PROG3:      rdata_nxt = fault_and_start_time_r;
      default:            rdata_nxt = `PTER_RST_ZERO;
    endcase
  end

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_o <= `PTER_RST_ZERO;
    end else if (rd_i) begin
      rdata_o <= rdata_nxt;
    end
  end
endmodule // pter_regs
`default_nettype wire

// >>> testbench/pter_regs_monitor.sv
// concurrent checks on the ports of the timing and event register bank
`timescale 1ns/1ps
`default_nettype none
module pter_regs_monitor (
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  addr_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  wdata_i,
  input wire logic [1:0]  disconnect_time_scale_i,
  input wire logic [1:0]  fault_timeout_scale_i,
  input wire logic [7:0]  detect_event_set_i,
  input wire logic        auto_pin_i,
  input wire logic [7:0]  rdata_o,
  input wire logic [3:0]  current_limit_code_o,
  input wire logic [3:0]  disconnect_time_code_o,
  input wire logic [3:0]  fault_timeout_code_o,
  input wire logic [31:0] disconnect_time_us_o,
  input wire logic [31:0] fault_timeout_us_o,
  input wire logic [31:0] startup_trip_voltage_uv_o,
  input wire logic [31:0] fault_trip_voltage_uv_o,
  input wire logic [7:0]  interrupt_mask_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // derived outputs lag reset release; hold off formula checks until settled
  logic [2:0] age_r;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) age_r <= 3'h0;
    else if (age_r != 3'h7) age_r <= age_r + 3'h1;
  end
  wire ok = (age_r == 3'h7);
  property p_flt;
    (ok && $stable(fault_timeout_code_o) && fault_timeout_scale_i == 2'h0)[*3]
      |-> fault_timeout_us_o == 32'd40960 + 32'd2720 * fault_timeout_code_o;
  endproperty
  a_flt: assert property (p_flt) else $error("fault timeout off");
  property p_dsc;
    (ok && $stable(disconnect_time_code_o) && disconnect_time_scale_i == 2'h3)[*3]
      |-> disconnect_time_us_o == 32'd2 * (32'd238000 + 32'd16000 * disconnect_time_code_o);
  endproperty
  a_dsc: assert property (p_dsc) else $error("doubled disconnect off");
  property p_vsu;
    (ok && $stable(current_limit_code_o))[*3]
      |-> startup_trip_voltage_uv_o == 32'd135000 + 32'd19250 * current_limit_code_o;
  endproperty
  a_vsu: assert property (p_vsu) else $error("startup trip off");
  property p_vft;
    (ok && $stable(startup_trip_voltage_uv_o))[*2]
      |-> fault_trip_voltage_uv_o == startup_trip_voltage_uv_o * 32'd88 / 32'd100;
  endproperty
  a_vft: assert property (p_vft) else $error("fault trip off");
  property p_rb;
    wr_i && addr_i == 8'h27 && !$past(rst_i) ##1 !wr_i ##1 rd_i && addr_i == 8'h27
      |=> rdata_o == $past(wdata_i, 3);
  endproperty
  a_rb: assert property (p_rb) else $error("program readback off");
  property p_cor;
    rd_i && addr_i == 8'h05 && detect_event_set_i == 8'h00 ##1 detect_event_set_i == 8'h00
      ##1 rd_i && addr_i == 8'h04 && detect_event_set_i == 8'h00 |=> rdata_o == 8'h00;
  endproperty
  a_cor: assert property (p_cor) else $error("flags kept after clear");
  property p_unm;
    rd_i && addr_i == 8'h30 |=> rdata_o == 8'h00;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_msk;
    $fell(rst_i) |=> interrupt_mask_o == {{3{$past(auto_pin_i)}}, 2'h0,
      $past(auto_pin_i), 2'h0};
  endproperty
  a_msk: assert property (p_msk) else $error("mask reset off");
endmodule // pter_regs_monitor
bind pter_regs pter_regs_monitor i_mon (.ref_clk_i, .rst_i, .addr_i, .wr_i, .rd_i, .wdata_i,
  .disconnect_time_scale_i, .fault_timeout_scale_i, .detect_event_set_i, .auto_pin_i, .rdata_o,
  .current_limit_code_o, .disconnect_time_code_o, .fault_timeout_code_o, .disconnect_time_us_o,
  .fault_timeout_us_o, .startup_trip_voltage_uv_o, .fault_trip_voltage_uv_o, .interrupt_mask_o);
`default_nettype wire

// >>> testbench/pse_timing_and_event_registers_tb_top.sv
// directed testbench of the timing and event register bank
`timescale 1ns/1ps
`default_nettype none
module pse_timing_and_event_registers_tb_top;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic auto_pin_i = 1'b1, midspan_pin_i = 1'b1;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, supply_event_init_i = 8'h00;
  logic [7:0] power_event_set_i = 8'h00, detect_event_set_i = 8'h00, fault_event_set_i = 8'h00;
  logic [7:0] startup_event_set_i = 8'h00, supply_event_set_i = 8'h00, power_state_i = 8'h5A;
  logic [7:0] port1_status_i = 8'h71, port2_status_i = 8'h72, port3_status_i = 8'h73;
  logic [7:0] port4_status_i = 8'h74, rdata_o, interrupt_mask_o, interrupt_summary_o;
  logic [1:0] disconnect_time_scale_i = 2'h0, fault_timeout_scale_i = 2'h0;
  logic [1:0] startup_timeout_scale_i = 2'h0;
  logic [3:0] slave_address_pins_i = 4'hA, current_limit_code_o, disconnect_time_code_o;
  logic [3:0] fault_timeout_code_o, startup_timeout_code_o;
  logic [31:0] disconnect_time_us_o, disconnect_time_cycles_o, fault_timeout_us_o;
  logic [31:0] fault_timeout_cycles_o, startup_timeout_us_o, startup_timeout_cycles_o;
  logic [31:0] startup_trip_voltage_uv_o, fault_trip_voltage_uv_o;
  int mismatches = 0;
  int n_tests = 0;
  pter_regs i_dut (.ref_clk_i, .rst_i, .addr_i, .wr_i, .rd_i, .wdata_i, .disconnect_time_scale_i,
    .fault_timeout_scale_i, .startup_timeout_scale_i, .power_event_set_i, .detect_event_set_i,
    .fault_event_set_i, .startup_event_set_i, .supply_event_set_i, .supply_event_init_i,
    .port1_status_i, .port2_status_i, .port3_status_i, .port4_status_i, .power_state_i,
    .auto_pin_i, .midspan_pin_i, .slave_address_pins_i, .rdata_o, .current_limit_code_o,
    .disconnect_time_code_o, .fault_timeout_code_o, .startup_timeout_code_o,
    .disconnect_time_us_o, .disconnect_time_cycles_o, .fault_timeout_us_o, .fault_timeout_cycles_o,
    .startup_timeout_us_o, .startup_timeout_cycles_o, .startup_trip_voltage_uv_o,
    .fault_trip_voltage_uv_o, .interrupt_mask_o, .interrupt_summary_o);
  always #25 ref_clk_i = ~ref_clk_i;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i) begin addr_i = a; wdata_i = d; wr_i = 1'b1; end
    @(negedge ref_clk_i) wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk_i) begin addr_i = a; rd_i = 1'b1; end
    @(negedge ref_clk_i) rd_i = 1'b0;
    chk({24'h0, rdata_o}, {24'h0, e});
  endtask
  task automatic t_reset;
    rd(8'h27, 8'h47);
    rd(8'h28, 8'h77);
    rd(8'h0A, 8'h35);
    rd(8'h11, 8'h2B);
    chk({24'h0, interrupt_mask_o}, 32'h000000E4);
    rd(8'h00, 8'h80);
    for (int i = 0; i < 4; i++) rd(8'h0C + i[7:0], 8'h71 + i[7:0]);
    rd(8'h10, 8'h5A);
    chk(disconnect_time_us_o, 32'd350000);
    chk(fault_timeout_us_o, 32'd60000);
    chk(startup_timeout_cycles_o, 32'd1200000);
    chk(startup_trip_voltage_uv_o, 32'd212000);
    chk(fault_trip_voltage_uv_o, 32'd186560);
    $display("reset defaults done");
  endtask
  task automatic t_prog;
    disconnect_time_scale_i = 2'h3;
    startup_timeout_scale_i = 2'h3;
    wr(8'h27, 8'h5F);
    rd(8'h27, 8'h5F);
    wr(8'h28, 8'hA3);
    rd(8'h28, 8'hA3);
    repeat (4) @(negedge ref_clk_i);
    chk({28'h0, current_limit_code_o}, 32'h5);
    chk({28'h0, disconnect_time_code_o}, 32'hF);
    chk({28'h0, fault_timeout_code_o}, 32'hA);
    chk({28'h0, startup_timeout_code_o}, 32'h3);
    chk(disconnect_time_us_o, 32'd956000);
    chk(disconnect_time_cycles_o, 32'd19120000);
    chk(fault_timeout_us_o, 32'd68160);
    chk(startup_timeout_us_o, 32'd98240);
    chk(startup_trip_voltage_uv_o, 32'd231250);
    chk(fault_trip_voltage_uv_o, 32'd203500);
    chk(fault_timeout_cycles_o, 32'd1363200);
    fault_timeout_scale_i = 2'h1;
    disconnect_time_scale_i = 2'h2;
    repeat (2) @(negedge ref_clk_i);
    chk(fault_timeout_us_o, 32'd17040);
    chk(disconnect_time_us_o, 32'd239000);
    fault_timeout_scale_i = 2'h0;
    wr(8'h01, 8'h5A);
    rd(8'h01, 8'h5A);
    chk({24'h0, interrupt_mask_o}, 32'h0000005A);
    $display("program registers done");
  endtask
  task automatic t_events;
    @(negedge ref_clk_i) begin
      power_event_set_i = 8'h11; detect_event_set_i = 8'h81; fault_event_set_i = 8'h42;
      startup_event_set_i = 8'h24; supply_event_set_i = 8'h80;
    end
    @(negedge ref_clk_i) begin
      power_event_set_i = 8'h00; detect_event_set_i = 8'h00; fault_event_set_i = 8'h00;
      startup_event_set_i = 8'h00; supply_event_set_i = 8'h00;
    end
    wr(8'h02, 8'hFF);
    rd(8'h02, 8'h11);
    rd(8'h06, 8'h42);
    rd(8'h04, 8'h81);
    @(negedge ref_clk_i) begin addr_i = 8'h05; rd_i = 1'b1; detect_event_set_i = 8'h02; end
    @(negedge ref_clk_i) begin rd_i = 1'b0; detect_event_set_i = 8'h00; end
    chk({24'h0, rdata_o}, 32'h00000081);
    rd(8'h04, 8'h02);
    rd(8'h05, 8'h02);
    rd(8'h04, 8'h00);
    rd(8'h09, 8'h24);
    rd(8'h08, 8'h00);
    rd(8'h0B, 8'hB5);
    rd(8'h0A, 8'h00);
    rd(8'h30, 8'h00);
    rd(8'h00, 8'h27);
    $display("event views done");
  endtask
  task automatic t_rerst;
    @(negedge ref_clk_i) begin rst_i = 1'b1; auto_pin_i = 1'b0; supply_event_init_i = 8'h40; end
    repeat (2) @(negedge ref_clk_i);
    rst_i = 1'b0;
    @(negedge ref_clk_i);
    chk({24'h0, interrupt_mask_o}, 32'h00000000);
    rd(8'h27, 8'h47);
    rd(8'h0B, 8'h75);
    rd(8'h11, 8'h2A);
    $display("mid-run reset done");
  endtask
  task automatic wrap_up;
    $display("tests=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge ref_clk_i);
    rst_i = 1'b0;
    @(negedge ref_clk_i);
    t_reset();
    t_prog();
    t_events();
    t_rerst();
    wrap_up();
  end
  // cut a hang short well past the normal run length
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end
endmodule // pse_timing_and_event_registers_tb_top
`default_nettype wire
